// ===== rtl/smr_map.vh
`ifndef SMR_MAP_VH
`define SMR_MAP_VH
// Bank codes selecting the target of a mode-set command
`define SMR_BANK_BASE      3'h0
`define SMR_BANK_EXT1      3'h1
// Base mode register fields
`define SMR_BL_LO          0
`define SMR_BL_HI          1
`define SMR_BT_BIT         3
`define SMR_CAS_LO         4
`define SMR_CAS_HI         6
`define SMR_TM_BIT         7
`define SMR_DLLRST_BIT     8
`define SMR_WR_LO          9
`define SMR_WR_HI          11
`define SMR_PPD_BIT        12
// First extended mode register fields
`define SMR_DLLDIS_BIT     0
`define SMR_DIC0_BIT       1
`define SMR_RTT0_BIT       2
`define SMR_AL_LO          3
`define SMR_AL_HI          4
`define SMR_DIC1_BIT       5
`define SMR_RTT1_BIT       6
`define SMR_WLEV_BIT       7
`define SMR_RTT2_BIT       9
`define SMR_TERMINATION_STROBE_BIT       11
`define SMR_QOFF_BIT       12
// Burst length codes
`define SMR_BL_FIX8        2'h0
`define SMR_BL_OTF         2'h1
`define SMR_BL_FIX4        2'h2
// Posted delay codes
`define SMR_AL_ZERO        2'h0
`define SMR_AL_M1          2'h1
`define SMR_AL_M2          2'h2
// Write start advance for a fixed chopped burst, in link clocks
`define SMR_CHOP_ADVANCE   4'h2
// Width of the address bus and reset value of the registers
`define SMR_ADDR_W         15
`define SMR_REG_RESET      15'h0000
`endif

// ===== rtl/smr_burst_order.v
`timescale 1ns/10ps
`default_nettype none
// Beat order for an eight-beat burst: index of the column for each beat
module smr_burst_order (
  // Burst setup
  input  wire [2:0]  start_col,
  input  wire        interleave,
  input  wire        is_write,
  // Eight 3-bit beat indices, beat 0 in the low bits
  output wire [23:0] order
);
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_beat
      localparam [2:0] BI = b;
      wire [2:0] bi = BI;
      wire [2:0] seq_ix;
      wire [2:0] il_ix;
      // Sequential wraps inside the nibble, nibble swaps with beat bit 2
      assign seq_ix = {start_col[2] ^ bi[2], start_col[1:0] + bi[1:0]};
      assign il_ix  = start_col ^ bi;
      assign order[3*b+2:3*b] = is_write ? bi :
                                (interleave ? il_ix : seq_ix);
    end
  endgenerate
endmodule // smr_burst_order
`default_nettype wire

// ===== rtl/smr_delay_line.v
`timescale 1ns/10ps
`default_nettype none
// Variable delay of a one-cycle event, counted in link clock enables
module smr_delay_line #(
  parameter DEPTH = 32
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Link clock enable and event
  input  wire       tick,
  input  wire       ev_in,
  input  wire [4:0] delay,
  // Delayed event
  output reg        ev_out
);
  reg [DEPTH-1:0] line;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line   <= {DEPTH{1'b0}};
      ev_out <= 1'b0;
    end else begin
      ev_out <= 1'b0;
      if (tick) begin
        line   <= {line[DEPTH-2:0], ev_in};
        ev_out <= (delay == 5'h00) ? ev_in : line[delay - 5'h01];
      end
    end
  end
endmodule // smr_delay_line
`default_nettype wire

// ===== rtl/smr_mode_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "smr_map.vh"
module smr_mode_regs #(
  parameter AW = `SMR_ADDR_W
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rstn,
  // Link pins from the controller
  input  wire          link_ck,
  input  wire          cke,
  input  wire          cs_n,
  input  wire          ras_n,
  input  wire          cas_n,
  input  wire          we_n,
  input  wire [2:0]    bank,
  input  wire [AW-1:0] addr,
  // Device status inputs
  input  wire          loop_reset_done,
  input  wire          self_refresh,
  input  wire          chop_select_pin,
  input  wire          rd_cmd,
  input  wire          wr_cmd,
  input  wire          wr_term_active,
  // Raw register contents
  output reg  [AW-1:0] base_mode_register,
  output reg  [AW-1:0] first_extended_mode_register,
  // Base register decode
  output reg  [1:0]    burst_len,
  output reg           interleave,
  output reg  [3:0]    read_cas_delay,
  output reg           test_mode,
  output reg           loop_reset,
  output reg  [3:0]    write_recovery,
  output reg           fast_pd_exit,
  output reg  [23:0]   read_order,
  output reg  [23:0]   write_order,
  // First extended register decode
  output reg           loop_enabled,
  output reg  [1:0]    drive_strength,
  output reg  [2:0]    nominal_term,
  output reg  [4:0]    posted_command_delay,
  output reg  [4:0]    total_read_delay,
  output reg           write_level_en,
  output reg           out_disable,
  output reg           termination_strobe_en,
  output reg           write_data_mask_en,
  // Derived timing and pin control
  output reg  [3:0]    write_start_advance,
  output reg           write_needs_loop,
  output reg           loop_frozen_in_pd,
  output reg           loop_running,
  output reg           rd_data_start,
  output wire          dq_oe,
  output wire          spare_strobe_oe
);
  // Two-flop synchronisers for all link inputs
  localparam SW = 10 + AW;
  reg [SW-1:0] sync1;
  reg [SW-1:0] sync2;
  reg          ck_prev;
  reg [1:0]    rd_sync;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1   <= {SW{1'b0}};
      sync2   <= {SW{1'b0}};
      ck_prev <= 1'b0;
      rd_sync <= 2'h0;
    end else begin
      rd_sync <= {rd_sync[0], rd_cmd};
      sync1   <= {link_ck, cke, cs_n, ras_n, cas_n, we_n, bank, addr,
                  chop_select_pin};
      sync2   <= sync1;
      ck_prev <= sync2[SW-1];
    end
  end
  wire          s_ck    = sync2[SW-1];
  wire          s_cke   = sync2[SW-2];
  wire          s_cs_n  = sync2[SW-3];
  wire          s_ras_n = sync2[SW-4];
  wire          s_cas_n = sync2[SW-5];
  wire          s_we_n  = sync2[SW-6];
  wire [2:0]    s_bank  = sync2[SW-7:SW-9];
  wire [AW-1:0] s_addr  = sync2[AW:1];
  wire          s_chop  = sync2[0];
  // Rising edge of the link clock is the command sample point
  wire tick = s_ck & ~ck_prev;
  wire mode_set = tick & s_cke & ~s_cs_n & ~s_ras_n & ~s_cas_n & ~s_we_n;

  // Register writes and self-clearing loop reset
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      base_mode_register           <= `SMR_REG_RESET;
      first_extended_mode_register <= `SMR_REG_RESET;
    end else begin
      if (mode_set && s_bank == `SMR_BANK_BASE) begin
        base_mode_register <= s_addr;
      end else if (loop_reset_done) begin
        base_mode_register[`SMR_DLLRST_BIT] <= 1'b0;
      end
      if (mode_set && s_bank == `SMR_BANK_EXT1) begin
        first_extended_mode_register <= s_addr;
      end
    end
  end

  // CAS code to cycles: 1..6 -> 5..10, 0 reserved left at 5
  wire [2:0] cas_code = base_mode_register[`SMR_CAS_HI:`SMR_CAS_LO];
  wire [3:0] cas_cyc  = {1'b0, cas_code} + 4'h4 + {3'h0, cas_code == 3'h0};
  wire [1:0] al_code  =
    first_extended_mode_register[`SMR_AL_HI:`SMR_AL_LO];
  reg  [4:0] next_al;
  always @* begin
    if (al_code == `SMR_AL_M1) begin
      next_al = {1'b0, cas_cyc} - 5'h01;
    end else if (al_code == `SMR_AL_M2) begin
      next_al = {1'b0, cas_cyc} - 5'h02;
    end else begin
      next_al = 5'h00; // Reserved code treated as zero
    end
  end
  wire [2:0] wr_code = base_mode_register[`SMR_WR_HI:`SMR_WR_LO];
  wire [1:0] bl_code = base_mode_register[`SMR_BL_HI:`SMR_BL_LO];

  // Burst order for the column sampled with the command
  wire [23:0] rd_ord;
  wire [23:0] wr_ord;
  smr_burst_order u_rd_order (
    .start_col  (s_addr[2:0]),
    .interleave (base_mode_register[`SMR_BT_BIT]),
    .is_write   (1'b0),
    .order      (rd_ord)
  );
  smr_burst_order u_wr_order (
    .start_col  (s_addr[2:0]),
    .interleave (base_mode_register[`SMR_BT_BIT]),
    .is_write   (1'b1),
    .order      (wr_ord)
  );

  // Registered decode outputs
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      burst_len             <= 2'h0;
      interleave            <= 1'b0;
      read_cas_delay        <= 4'h0;
      test_mode             <= 1'b0;
      loop_reset            <= 1'b0;
      write_recovery        <= 4'h0;
      fast_pd_exit          <= 1'b0;
      read_order            <= 24'h000000;
      write_order           <= 24'h000000;
      loop_enabled          <= 1'b0;
      drive_strength        <= 2'h0;
      nominal_term          <= 3'h0;
      posted_command_delay  <= 5'h00;
      total_read_delay      <= 5'h00;
      write_level_en        <= 1'b0;
      out_disable           <= 1'b0;
      termination_strobe_en <= 1'b0;
      write_data_mask_en    <= 1'b1;
      write_start_advance   <= 4'h0;
      write_needs_loop      <= 1'b0;
      loop_frozen_in_pd     <= 1'b0;
      loop_running          <= 1'b0;
    end else begin
      burst_len      <= bl_code;
      interleave     <= base_mode_register[`SMR_BT_BIT];
      read_cas_delay <= cas_cyc;
      test_mode      <= base_mode_register[`SMR_TM_BIT];
      loop_reset     <= base_mode_register[`SMR_DLLRST_BIT];
      // Codes 1..3 give 5..7, 4..7 give 8,10,12,14, 0 reserved as 15
      if (wr_code == 3'h0) begin
        write_recovery <= 4'hF;
      end else if (wr_code < 3'h4) begin
        write_recovery <= {1'b0, wr_code} + 4'h4;
      end else begin
        write_recovery <= {wr_code, 1'b0};
      end
      fast_pd_exit      <= base_mode_register[`SMR_PPD_BIT];
      loop_frozen_in_pd <= ~base_mode_register[`SMR_PPD_BIT];
      if (mode_set && s_bank == `SMR_BANK_BASE) begin
        read_order  <= read_order;
        write_order <= write_order;
      end else if (tick && s_cke && ~s_cs_n && s_ras_n && ~s_cas_n) begin
        // Read order follows the column of each read or write command, write order is always beats 0 to 7
        read_order  <= rd_ord;
        write_order <= wr_ord;
      end
      loop_enabled <=
        ~first_extended_mode_register[`SMR_DLLDIS_BIT];
      drive_strength <= {first_extended_mode_register[`SMR_DIC1_BIT],
                         first_extended_mode_register[`SMR_DIC0_BIT]};
      nominal_term <= {first_extended_mode_register[`SMR_RTT2_BIT],
                       first_extended_mode_register[`SMR_RTT1_BIT],
                       first_extended_mode_register[`SMR_RTT0_BIT]};
      posted_command_delay <= next_al;
      total_read_delay     <= next_al + {1'b0, cas_cyc};
      write_level_en <= first_extended_mode_register[`SMR_WLEV_BIT];
      out_disable    <= first_extended_mode_register[`SMR_QOFF_BIT];
      termination_strobe_en <=
        first_extended_mode_register[`SMR_TERMINATION_STROBE_BIT];
      write_data_mask_en <=
        ~first_extended_mode_register[`SMR_TERMINATION_STROBE_BIT];
      if (bl_code == `SMR_BL_FIX4) begin
        write_start_advance <= `SMR_CHOP_ADVANCE;
      end else begin
        write_start_advance <= 4'h0;
      end
      // Write termination keeps writes on the loop even with nominal off
      write_needs_loop <= wr_term_active;
      loop_running <= ~first_extended_mode_register[`SMR_DLLDIS_BIT] &
                      ~self_refresh;
    end
  end

  // Read timing: event delayed by total read delay in link clocks
  // Read request is synchronised alongside the command pins
  wire rd_evt = rd_sync[1] & tick;
  wire rd_first;
  smr_delay_line #(.DEPTH(32)) u_rd_delay (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (tick),
    .ev_in   (rd_evt),
    .delay   (total_read_delay),
    .ev_out  (rd_first)
  );
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_start <= 1'b0;
    end else begin
      rd_data_start <= rd_first;
    end
  end

  // Output window: four link clocks per burst, two for a chopped one
  reg       rd_chop;
  reg [2:0] beat_cnt;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_chop  <= 1'b0;
      beat_cnt <= 3'h0;
    end else begin
      if (rd_evt) begin
        rd_chop <= (bl_code == `SMR_BL_FIX4) ||
                   (bl_code == `SMR_BL_OTF && ~s_chop);
      end
      if (rd_first) begin
        beat_cnt <= 3'h4;
      end else if (tick && beat_cnt != 3'h0) begin
        beat_cnt <= beat_cnt - 3'h1;
      end
    end
  end
  // Second half of a chopped read stays high impedance
  wire drive_half = (beat_cnt > 3'h2) || (!rd_chop && beat_cnt != 3'h0);
  assign dq_oe = drive_half & ~out_disable;
  assign spare_strobe_oe = dq_oe & termination_strobe_en;
endmodule // smr_mode_regs
`default_nettype wire

// ===== tb/smr_mode_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module smr_mode_regs_monitor (
  // Clock and reset
  input wire        ref_clk,
  input wire        rstn,
  // Pins and status
  input wire        cs_n,
  input wire        loop_reset_done,
  input wire        self_refresh,
  // Registers and decodes
  input wire [14:0] base_mode_register,
  input wire [14:0] first_extended_mode_register,
  input wire [1:0]  drive_strength,
  input wire [2:0]  nominal_term,
  input wire [3:0]  read_cas_delay,
  input wire [4:0]  posted_command_delay,
  input wire [4:0]  total_read_delay,
  input wire [3:0]  write_start_advance,
  input wire        out_disable,
  input wire        termination_strobe_en,
  input wire        write_data_mask_en,
  input wire        loop_running,
  input wire        dq_oe,
  input wire        spare_strobe_oe
);
  wire [14:0] r0 = base_mode_register;
  wire [14:0] r1 = first_extended_mode_register;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_DRIVE: assert property (
    drive_strength == $past({r1[5], r1[1]}))
    else $error("drive strength decode wrong");
  AST_TERM: assert property (
    nominal_term == $past({r1[9], r1[6], r1[2]}))
    else $error("nominal termination decode wrong");
  AST_ADVANCE: assert property (
    write_start_advance == (($past(r0[1:0]) == 2'h2) ? 4'h2 : 4'h0))
    else $error("write start advance wrong");
  AST_POSTED: assert property (
    $past(r1[4]) != $past(r1[3]) |->
    posted_command_delay == {1'b0, read_cas_delay} - {3'h0, $past(r1[4:3])})
    else $error("posted delay wrong");
  AST_TOTAL: assert property (
    total_read_delay == posted_command_delay + {1'b0, read_cas_delay})
    else $error("total read delay wrong");
  AST_QOFF: assert property (
    out_disable |-> !dq_oe)
    else $error("data driven while outputs disabled");
  AST_MASK: assert property (
    (write_data_mask_en != termination_strobe_en) &&
    (termination_strobe_en || !spare_strobe_oe))
    else $error("mask and strobe pin choice wrong");
  AST_LOOPCLR: assert property (
    loop_reset_done && cs_n |=> !base_mode_register[8])
    else $error("loop reset bit did not clear");
  AST_SREF: assert property (
    self_refresh [*2] |-> !loop_running)
    else $error("loop running in self refresh");
endmodule // smr_mode_regs_monitor
bind smr_mode_regs smr_mode_regs_monitor i_mon (.*);
`default_nettype wire

// ===== tb/smr_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module smr_ctrl_model (
  // System clock
  input  wire logic        ref_clk,
  // Link pins
  output var logic         link_ck,
  output var logic         cke,
  output var logic         cs_n,
  output var logic         ras_n,
  output var logic         cas_n,
  output var logic         we_n,
  output var logic [2:0]   bank,
  output var logic [14:0]  addr,
  output var logic         chop_select_pin,
  output var logic         rd_cmd
);
  time t_cmd;
  // Free running link clock, phase unrelated to ref_clk
  initial begin
    link_ck = 1'b0;
    // Clock enable stays high for the whole run
    {cke, cs_n, ras_n, cas_n, we_n, rd_cmd, chop_select_pin} = 7'h7D;
    bank = 3'h5;
    addr = 15'h2A55;
    #37;
    forever #100 link_ck = ~link_ck;
  end
  // Pins set in the low half, held past the rising edge, then scrambled
  task automatic send(input logic [6:0] p, input logic [2:0] b,
                      input logic [14:0] a);
    @(negedge link_ck);
    @(negedge ref_clk);
    {cke, cs_n, ras_n, cas_n, we_n, rd_cmd, chop_select_pin} = p;
    bank = b;
    addr = a;
    @(posedge link_ck);
    t_cmd = $time;
    @(negedge link_ck);
    @(negedge ref_clk);
    {cke, cs_n, ras_n, cas_n, we_n, rd_cmd, chop_select_pin} =
      {2'h3, ~p[4:2], 1'b0, ~p[0]};
    bank = ~b;
    addr = ~a;
  endtask
  task automatic mode_set(input logic [2:0] b, input logic [14:0] a);
    send(7'h41, b, a);
  endtask
  task automatic rd(input logic chop, input logic [2:0] col);
    send({6'h2B, chop}, 3'h0, {12'h000, col});
  endtask
endmodule // smr_ctrl_model
`default_nettype wire

// ===== tb/sdram_mode_reg_decode_test.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_mode_reg_decode_test;
  typedef struct packed {logic [14:0] a0; logic [14:0] a1;
                         logic [18:0] st;} smr_row_t;
  logic        ref_clk, rstn, loop_reset_done, self_refresh;
  logic        wr_term_active, wr_cmd;
  wire         link_ck, cke, cs_n, ras_n, cas_n, we_n, chop_select_pin;
  wire         rd_cmd, interleave, test_mode, loop_reset, fast_pd_exit;
  wire  [2:0]  bank, nominal_term;
  wire  [14:0] addr, base_mode_register, first_extended_mode_register;
  wire  [1:0]  burst_len, drive_strength;
  wire  [3:0]  read_cas_delay, write_recovery, write_start_advance;
  wire  [4:0]  posted_command_delay, total_read_delay;
  wire  [23:0] read_order, write_order;
  wire         loop_enabled, write_level_en, out_disable, dq_oe;
  wire         termination_strobe_en, write_data_mask_en, write_needs_loop;
  wire         loop_frozen_in_pd, loop_running, rd_data_start;
  wire         spare_strobe_oe;
  int          miscompares, n_checks, cycles, k, cnt;
  smr_row_t    rows [3] = '{'{15'h0000, 15'h0000, 19'h40005},
                            '{15'h108A, 15'h1803, 19'h2E48A},
                            '{15'h0001, 15'h0060, 19'h50125}};
  smr_mode_regs  i_dut (.*);
  smr_ctrl_model i_ctrl (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  function automatic logic [18:0] stat();
    return {loop_frozen_in_pd, burst_len, interleave, test_mode, fast_pd_exit,
            write_start_advance, drive_strength, nominal_term,
            termination_strobe_en, write_data_mask_en, out_disable,
            loop_enabled};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      miscompares++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {loop_reset_done, self_refresh, wr_term_active, wr_cmd} = 4'h0;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    settle();
    chk(stat(), 19'h40005);
    foreach (rows[i]) begin
      i_ctrl.mode_set(3'h0, rows[i].a0);
      i_ctrl.mode_set(3'h1, rows[i].a1);
      settle();
      chk(stat(), rows[i].st);
      chk(base_mode_register, rows[i].a0);
      $display("row %0d done", i);
    end
    i_ctrl.mode_set(3'h2, 15'h7FFF);
    settle();
    chk(first_extended_mode_register, rows[2].a1);
    i_ctrl.mode_set(3'h0, 15'h0B00);
    settle();
    chk(loop_reset, 1'b1);
    chk(write_recovery, 4'hA);
    loop_reset_done = 1'b1;
    @(negedge ref_clk);
    loop_reset_done = 1'b0;
    settle();
    chk({loop_reset, base_mode_register[8]}, 2'h0);
    self_refresh = 1'b1;
    settle();
    chk(loop_running, 1'b0);
    self_refresh = 1'b0;
    wr_term_active = 1'b1;
    settle();
    chk({loop_running, write_needs_loop}, 2'h3);
    wr_term_active = 1'b0;
    $display("loop tests done");
    for (int i = 0; i < 2; i++) begin
      i_ctrl.mode_set(3'h0, i ? 15'h0029 : 15'h0021);
      i_ctrl.mode_set(3'h1, i ? 15'h0010 : 15'h0008);
      i_ctrl.rd(i[0], 3'h5);
      k = 0;
      while (rd_data_start !== 1'b1 && k < 400) begin
        @(negedge ref_clk);
        k++;
      end
      chk_n(int'(($time - i_ctrl.t_cmd) / 200), i ? 10 : 11);
      chk(read_order, i ? {3'd2, 3'd3, 3'd0, 3'd1, 3'd6, 3'd7, 3'd4, 3'd5}
                        : {3'd0, 3'd3, 3'd2, 3'd1, 3'd4, 3'd7, 3'd6, 3'd5});
      chk(write_order, {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0});
      cnt = 0;
      repeat (64) begin
        cnt += (dq_oe === 1'b1);
        @(negedge ref_clk);
      end
      chk_n((cnt + 4) / 8, i ? 4 : 2);
      $display("read %0d done", i);
    end
    final_report();
  end
endmodule // sdram_mode_reg_decode_test
`default_nettype wire
